// *** core/pdm_device.sv ***
`timescale 1ns/1ns
//
// Behaviour
// - host port stop bit gates its clock
// - redundancy stop bit gates redundancy clock
// - software sets redundancy stop after reset
// - reserved stop bits read zero, write zero
// - halt with select clear enters sleep
// - sleep keeps peripherals and clock pin
// - accepted interrupts end sleep, take exception
// - masked irq or peripheral keeps sleep
// - power-on or debug reset ends sleep
// - halt with select set enters standby
// - standby clears compare timer registers only
// - software stops, zeroes, configures watchdog first
// - nmi/irq wakes standby after watchdog interval
// - select still set: re-enter standby at 0x80
// - irq wakes standby only if not level sense
// - masked irq wake resumes after halt
// - reset held low until oscillator settles
// - reset from standby restarts clock pin at once
// - stop bit cuts peripheral clock, keeps registers
// - stop bit cleared or reset ends module standby
module pdm_device #(
  parameter int unsigned PRESCALE_MAX = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  pdm_if.device bus,
  output logic o_host_port_clk,
  output logic o_redundancy_clk,
  output logic o_clock_pin_en,
  output logic o_periph_clk_en,
  output logic o_cpu_clk_en,
  output logic o_timer_clear,
  output pdm_pkg::pdm_state_t o_state
);
  import pdm_pkg::*;

  pdm_state_t state_q, state_d;
  logic [REG_W-1:0] stop4_q, stop4_d;
  logic [REG_W-1:0] wdt_q, wdt_d;
  logic [REG_W-1:0] pre_q, pre_d;
  logic clock_pin_q, clock_pin_d;
  logic periph_q, periph_d;
  logic cpu_q, cpu_d;
  logic timer_clr_q, timer_clr_d;
  logic exc_q, exc_d;
  logic resume_q, resume_d;
  logic nmi_q, irq_q;
  logic prev_irq_q;
  logic irq_edge;
  logic irq_accept, periph_accept, sleep_wake, standby_wake;
  logic [REG_W-1:0] pre_limit;

  // prescale length chosen by watchdog clock select: 2^cks cycles per tick
  function automatic logic [REG_W-1:0] tick_len(input logic [2:0] cks);
    tick_len = REG_W'(1) << cks;
  endfunction : tick_len

  // wake sources; sleep irq and peripheral masked by priority compared against the cpu mask level
  always_comb begin
    irq_edge = bus.irq & !prev_irq_q;
    irq_accept = bus.irq && (bus.irq_prio > bus.mask_level);
    periph_accept = bus.periph_irq &&
                    (bus.periph_prio > bus.mask_level);
    sleep_wake = bus.nmi | irq_accept | periph_accept | bus.ubreak |
                 bus.debug_irq;
    // level-sense irq cannot wake standby: the clocks that detect it stop
    standby_wake = bus.nmi |
                   ((bus.irq_sense != SENSE_LOW_LEVEL) && irq_edge);
    pre_limit = tick_len(bus.wdt_clock_select);
  end

  // mode sequencing, watchdog settling counter and stop register
  always_comb begin
    state_d = state_q;
    stop4_d = stop4_q;
    wdt_d = wdt_q;
    pre_d = pre_q;
    clock_pin_d = clock_pin_q;
    periph_d = periph_q;
    cpu_d = cpu_q;
    timer_clr_d = 1'b0;
    exc_d = 1'b0;
    resume_d = 1'b0;
    if (bus.reg_wr) begin
      stop4_d = bus.reg_wdata & STOP4_WRITABLE;
    end
    if (bus.wdt_clear) begin
      wdt_d = WDT_ZERO;
      pre_d = WDT_ZERO;
    end
    case (state_q)
      PDM_RUN: begin
        if (bus.halt_req && !bus.standby_select) begin
          state_d = PDM_SLEEP;
          cpu_d = 1'b0;
        end else if (bus.halt_req && bus.standby_select) begin
          state_d = PDM_STANDBY;
          cpu_d = 1'b0;
          periph_d = 1'b0;
          clock_pin_d = 1'b0;
          timer_clr_d = 1'b1;
        end else if (bus.standby_select && wdt_q != WDT_ZERO) begin
          // counter keeps running after a wake until select is cleared
          if (pre_q + WDT_ONE >= pre_limit) begin
            pre_d = WDT_ZERO;
            wdt_d = wdt_q + WDT_ONE;
          end else begin
            pre_d = pre_q + WDT_ONE;
          end
          if (wdt_q == WDT_REENTRY) begin
            state_d = PDM_STANDBY;
            cpu_d = 1'b0;
            periph_d = 1'b0;
            clock_pin_d = 1'b0;
            timer_clr_d = 1'b1;
            wdt_d = WDT_ZERO;
          end
        end else if (!bus.standby_select) begin
          wdt_d = WDT_ZERO;
        end
      end
      PDM_SLEEP: begin
        // peripherals and clock pin stay on through sleep
        periph_d = 1'b1;
        clock_pin_d = 1'b1;
        if (bus.debug_reset) begin
          state_d = PDM_RUN;
          cpu_d = 1'b1;
        end else if (sleep_wake) begin
          state_d = PDM_RUN;
          cpu_d = 1'b1;
          exc_d = 1'b1;
        end
      end
      PDM_STANDBY: begin
        if (standby_wake) begin
          state_d = PDM_SETTLE;
          pre_d = WDT_ZERO;
          wdt_d = WDT_ZERO;
        end
      end
      PDM_SETTLE: begin
        // settle until the watchdog counter reaches its overflow mark
        if (pre_q + WDT_ONE >= pre_limit) begin
          pre_d = WDT_ZERO;
          wdt_d = wdt_q + WDT_ONE;
        end else begin
          pre_d = pre_q + WDT_ONE;
        end
        if (wdt_q == WDT_REENTRY) begin
          state_d = PDM_RUN;
          wdt_d = WDT_ONE;
          cpu_d = 1'b1;
          periph_d = 1'b1;
          clock_pin_d = 1'b1;
          if (nmi_q || irq_q) begin
            exc_d = 1'b1;
          end else begin
            resume_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = PDM_RUN;
      end
    endcase
  end

  // power-on reset restores run mode; clock pin restarts at once
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_q <= PDM_RUN;
      stop4_q <= STOP4_RESET;
      wdt_q <= WDT_ZERO;
      pre_q <= WDT_ZERO;
      clock_pin_q <= 1'b1;
      periph_q <= 1'b1;
      cpu_q <= 1'b1;
      timer_clr_q <= 1'b0;
      exc_q <= 1'b0;
      resume_q <= 1'b0;
      nmi_q <= 1'b0;
      irq_q <= 1'b0;
      prev_irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      stop4_q <= stop4_d;
      wdt_q <= wdt_d;
      pre_q <= pre_d;
      clock_pin_q <= clock_pin_d;
      periph_q <= periph_d;
      cpu_q <= cpu_d;
      timer_clr_q <= timer_clr_d;
      exc_q <= exc_d;
      resume_q <= resume_d;
      prev_irq_q <= bus.irq;
      // remember which wake source was accepted past the mask
      if (state_q == PDM_STANDBY && standby_wake) begin
        nmi_q <= bus.nmi;
        irq_q <= irq_accept;
      end
    end
  end

  // per-module gated clocks
  pdm_clk_gate u_host_gate (
    .i_clk(i_clk),
    .i_stop(stop4_q[HOST_PORT_STOP_BIT] | !periph_q),
    .o_gclk(o_host_port_clk)
  );
  pdm_clk_gate u_red_gate (
    .i_clk(i_clk),
    .i_stop(stop4_q[REDUNDANCY_STOP_BIT] | !periph_q),
    .o_gclk(o_redundancy_clk)
  );

  assign bus.reg_rdata = stop4_q;
  assign bus.cpu_halted = !cpu_q;
  assign bus.take_exception = exc_q;
  assign bus.resume_next = resume_q;
  assign bus.mode = state_q;
  assign o_clock_pin_en = clock_pin_q;
  assign o_periph_clk_en = periph_q;
  assign o_cpu_clk_en = cpu_q;
  assign o_timer_clear = timer_clr_q;
  assign o_state = state_q;
endmodule : pdm_device

// *** core/pdm_pkg.sv ***
package pdm_pkg;
  // module_clock_stop_4 field positions
  localparam int unsigned REG_W = 8;
  localparam int unsigned HOST_PORT_STOP_BIT = 4;
  localparam int unsigned REDUNDANCY_STOP_BIT = 0;
  localparam logic [7:0] STOP4_WRITABLE = 8'h11;
  localparam logic [7:0] STOP4_RESET = 8'h00;
  // watchdog counter value that forces standby re-entry
  localparam logic [7:0] WDT_REENTRY = 8'h80;
  localparam logic [7:0] WDT_ZERO = 8'h00;
  localparam logic [7:0] WDT_ONE = 8'h01;
  // irq sense mode value meaning level detection
  localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
  localparam int unsigned PRIO_W = 4;
  localparam int unsigned PRESCALE_W = 3;

  typedef enum logic [1:0] {
    PDM_RUN = 2'b00,
    PDM_SLEEP = 2'b01,
    PDM_STANDBY = 2'b10,
    PDM_SETTLE = 2'b11
  } pdm_state_t;
endpackage : pdm_pkg

// *** core/pdm_if.sv ***
`timescale 1ns/1ns
// link between the cpu-side controller and the power-down device
interface pdm_if;
  import pdm_pkg::*;
  logic halt_req;
  logic standby_select;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic wdt_clear;
  logic [2:0] wdt_clock_select;
  logic nmi;
  logic irq;
  logic [1:0] irq_sense;
  logic [PRIO_W-1:0] irq_prio;
  logic [PRIO_W-1:0] mask_level;
  logic periph_irq;
  logic [PRIO_W-1:0] periph_prio;
  logic ubreak;
  logic debug_irq;
  logic debug_reset;
  logic cpu_halted;
  logic take_exception;
  logic resume_next;
  logic [1:0] mode;
  modport device (
    input halt_req, standby_select, reg_wr, reg_wdata, wdt_clear,
    input wdt_clock_select, nmi, irq, irq_sense, irq_prio, mask_level,
    input periph_irq, periph_prio, ubreak, debug_irq, debug_reset,
    output reg_rdata, cpu_halted, take_exception, resume_next, mode
  );
  modport ctrl (
    output halt_req, standby_select, reg_wr, reg_wdata, wdt_clear,
    output wdt_clock_select, nmi, irq, irq_sense, irq_prio, mask_level,
    output periph_irq, periph_prio, ubreak, debug_irq, debug_reset,
    input reg_rdata, cpu_halted, take_exception, resume_next, mode
  );
endinterface : pdm_if

// *** core/pdm_clk_gate.sv ***
`timescale 1ns/1ns
// glitch-free gate: enable changes only while the clock is low
module pdm_clk_gate (
  input wire logic i_clk,
  input wire logic i_stop,
  output logic o_gclk
);
  import pdm_pkg::*;
  logic en_lat;
  // latch is transparent while clock is low, so no runt pulse escapes
  always_latch begin
    if (!i_clk) begin
      en_lat <= !i_stop;
    end
  end
  assign o_gclk = i_clk & en_lat;
endmodule : pdm_clk_gate

// *** core/pdm_ctrl.sv ***
`timescale 1ns/1ns
// cpu-side end: stages user requests onto the link
module pdm_ctrl (
  input wire logic i_clk,
  input wire logic i_rst_b,
  pdm_if.ctrl bus,
  input wire logic i_halt,
  input wire logic i_standby_select,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [2:0] i_wdt_cks,
  input wire logic i_nmi,
  input wire logic i_irq,
  input wire logic [1:0] i_irq_sense,
  input wire logic [pdm_pkg::PRIO_W-1:0] i_irq_prio,
  input wire logic [pdm_pkg::PRIO_W-1:0] i_mask_level,
  input wire logic i_periph_irq,
  input wire logic [pdm_pkg::PRIO_W-1:0] i_periph_prio,
  input wire logic i_ubreak,
  input wire logic i_debug_irq,
  input wire logic i_debug_reset,
  output logic [7:0] o_reg_rdata,
  output logic o_exception,
  output logic o_resume
);
  import pdm_pkg::*;
  logic started_q, started_d;
  logic halt_q, halt_d;
  logic sel_q, sel_d;
  logic wr_q, wr_d;
  logic clr_q, clr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] rdata_q;
  logic exc_q, res_q;

  // first cycle after reset writes the redundancy stop bit
  always_comb begin
    started_d = 1'b1;
    halt_d = i_halt;
    sel_d = i_standby_select;
    clr_d = i_halt && i_standby_select;
    wr_d = i_reg_wr | !started_q;
    wdata_d = i_reg_wdata & STOP4_WRITABLE;
    if (!started_q) begin
      wdata_d = STOP4_WRITABLE & (8'h01 << REDUNDANCY_STOP_BIT);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      started_q <= 1'b0;
      halt_q <= 1'b0;
      sel_q <= 1'b0;
      wr_q <= 1'b0;
      clr_q <= 1'b0;
      wdata_q <= STOP4_RESET;
      rdata_q <= STOP4_RESET;
      exc_q <= 1'b0;
      res_q <= 1'b0;
    end else begin
      started_q <= started_d;
      halt_q <= halt_d;
      sel_q <= sel_d;
      wr_q <= wr_d;
      clr_q <= clr_d;
      wdata_q <= wdata_d;
      rdata_q <= bus.reg_rdata;
      exc_q <= bus.take_exception;
      res_q <= bus.resume_next;
    end
  end

  assign bus.halt_req = halt_q;
  assign bus.standby_select = sel_q;
  assign bus.reg_wr = wr_q;
  assign bus.reg_wdata = wdata_q;
  assign bus.wdt_clear = clr_q;
  assign bus.wdt_clock_select = i_wdt_cks;
  assign bus.nmi = i_nmi;
  assign bus.irq = i_irq;
  assign bus.irq_sense = i_irq_sense;
  assign bus.irq_prio = i_irq_prio;
  assign bus.mask_level = i_mask_level;
  assign bus.periph_irq = i_periph_irq;
  assign bus.periph_prio = i_periph_prio;
  assign bus.ubreak = i_ubreak;
  assign bus.debug_irq = i_debug_irq;
  assign bus.debug_reset = i_debug_reset;
  assign o_reg_rdata = rdata_q;
  assign o_exception = exc_q;
  assign o_resume = res_q;
endmodule : pdm_ctrl

// *** bench/pdm_properties.sv ***
`timescale 1ns/1ns
// link watcher; everything is quiet while reset is low
module pdm_properties (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic halt_req,
  input wire logic standby_select,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic nmi,
  input wire logic irq,
  input wire logic [1:0] irq_sense,
  input wire logic [pdm_pkg::PRIO_W-1:0] irq_prio,
  input wire logic [pdm_pkg::PRIO_W-1:0] mask_level,
  input wire logic periph_irq,
  input wire logic [pdm_pkg::PRIO_W-1:0] periph_prio,
  input wire logic ubreak,
  input wire logic debug_irq,
  input wire logic debug_reset,
  input wire logic cpu_halted,
  input wire logic take_exception,
  input wire logic resume_next,
  input wire logic [1:0] mode
);
  import pdm_pkg::*;
  logic wake_src;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // any accepted source; equal priority counts as masked
  assign wake_src = nmi | ubreak | debug_irq | debug_reset |
    (irq && irq_prio > mask_level) | (periph_irq && periph_prio > mask_level);
  a_sleep_entry: assert property (
    halt_req && !standby_select && mode == 2'h0 |=> mode == 2'h1 && cpu_halted)
    else $error("sleep entry missed");
  a_standby_entry: assert property (
    halt_req && standby_select && mode == 2'h0 |=> mode == 2'h2)
    else $error("standby entry missed");
  a_sleep_wake: assert property (
    mode == 2'h1 && (nmi || ubreak || debug_irq) |=> mode == 2'h0 && take_exception)
    else $error("sleep wake missed");
  a_masked_sleep: assert property (
    mode == 2'h1 && !wake_src |=> mode == 2'h1)
    else $error("sleep left without cause");
  a_debug_reset: assert property (
    mode == 2'h1 && debug_reset |=> mode == 2'h0)
    else $error("reset did not end sleep");
  a_reserved_zero: assert property (
    (reg_rdata & ~STOP4_WRITABLE) == 8'h00)
    else $error("reserved bits not zero");
  a_reg_write: assert property (
    reg_wr |=> reg_rdata == ($past(reg_wdata) & STOP4_WRITABLE))
    else $error("stop register write lost");
  a_level_ignored: assert property (
    mode == 2'h2 && irq_sense == SENSE_LOW_LEVEL && !nmi && !debug_reset
    |=> mode == 2'h2) else $error("level irq woke standby");
  a_settle_bound: assert property (
    $rose(mode == 2'h3) |-> ##[1:1000] mode == 2'h0)
    else $error("settle never ended");
  c_sleep_exc: cover property (mode == 2'h1 ##1 take_exception);
  c_resume: cover property (resume_next);
  c_settle: cover property ($rose(mode == 2'h3));
  c_standby_exc: cover property (mode == 2'h3 ##1 take_exception);
endmodule : pdm_properties

// *** bench/power_down_mode_controller_tb.sv ***
`timescale 1ns/1ns
// drives the ctrl user side, watches device outputs
module power_down_mode_controller_tb;
  import pdm_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic halt = 0, sel = 0, wr = 0, nmi = 0, irq = 0, pirq = 0;
  logic ub = 0, dbi = 0, dbr = 0, exc, res, hclk, rclk, pin_en, per_en;
  logic cpu_en, tclr;
  logic [7:0] wd = 8'h00, rdata;
  logic [2:0] cks = 3'h0;
  logic [1:0] sense = 2'h1;
  logic [PRIO_W-1:0] iprio = 4'h0, mask = 4'h8, pprio = 4'h0;
  pdm_state_t st;
  int bad_count = 0, checks = 0, exc_n = 0, res_n = 0, clr_n = 0;
  logic [31:0] rng = 32'ha08c;
  pdm_if link ();
  pdm_ctrl pdm_ctrl_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(link),
    .i_halt(halt), .i_standby_select(sel), .i_reg_wr(wr), .i_reg_wdata(wd),
    .i_wdt_cks(cks), .i_nmi(nmi), .i_irq(irq), .i_irq_sense(sense),
    .i_irq_prio(iprio), .i_mask_level(mask), .i_periph_irq(pirq),
    .i_periph_prio(pprio), .i_ubreak(ub), .i_debug_irq(dbi),
    .i_debug_reset(dbr), .o_reg_rdata(rdata), .o_exception(exc),
    .o_resume(res));
  pdm_device pdm_device_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(link),
    .o_host_port_clk(hclk), .o_redundancy_clk(rclk),
    .o_clock_pin_en(pin_en), .o_periph_clk_en(per_en),
    .o_cpu_clk_en(cpu_en), .o_timer_clear(tclr), .o_state(st));
  pdm_properties pdm_properties_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .halt_req(link.halt_req), .standby_select(link.standby_select),
    .reg_wr(link.reg_wr), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .nmi(link.nmi), .irq(link.irq),
    .irq_sense(link.irq_sense), .irq_prio(link.irq_prio),
    .mask_level(link.mask_level), .periph_irq(link.periph_irq),
    .periph_prio(link.periph_prio), .ubreak(link.ubreak),
    .debug_irq(link.debug_irq), .debug_reset(link.debug_reset),
    .cpu_halted(link.cpu_halted), .take_exception(link.take_exception),
    .resume_next(link.resume_next), .mode(link.mode));
  initial begin
    forever #2 i_clk = ~i_clk;
  end
  // pulse counters, since pulses stand for a single cycle
  always @(posedge i_clk) begin
    if (exc === 1'b1) exc_n++;
    if (res === 1'b1) res_n++;
    if (tclr === 1'b1) clr_n++;
  end
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : rnd
  function automatic logic [7:0] exp_reg(input logic [7:0] v);
    return v & STOP4_WRITABLE;
  endfunction : exp_reg
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check_byte
  task automatic check_state(input pdm_state_t got, input pdm_state_t exp);
    check_byte({6'h00, got}, {6'h00, exp});
  endtask : check_state
  // bounded wait, so a stuck state fails instead of hanging
  task automatic wait_state(input pdm_state_t s, input int lim);
    int k;
    k = 0;
    while (st !== s && k < lim) begin
      cyc(1);
      k++;
    end
    check_state(st, s);
  endtask : wait_state
  task automatic halt_to(input logic s);
    sel = s;
    halt = 1;
    cyc(1);
    halt = 0;
    cyc(3);
  endtask : halt_to
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (30000) @(posedge i_clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] v;
    logic [31:0] r;
    int n0;
    cyc(8);
    i_rst_b = 1;
    cyc(4);
    check_byte(rdata, 8'h01);
    $display("test reset done");
    // corners first, last write leaves the host port stopped
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : (i == 7) ? 8'h10 : r[7:0];
      wd = v;
      wr = 1;
      cyc(1);
      wr = 0;
      cyc(3);
      check_byte(rdata, exp_reg(v));
      check_byte({7'h00, hclk}, {7'h00, !v[4]});
      check_byte({7'h00, rclk}, {7'h00, !v[0]});
    end
    $display("test regs done");
    for (int s = 0; s < 6; s++) begin
      halt_to(1'b0);
      check_state(st, PDM_SLEEP);
      check_byte({6'h00, pin_en, per_en}, 8'h03);
      r = rnd();
      mask = 4'(r[3:0] % 14) + 4'h1;
      pprio = mask;
      iprio = mask - 4'h1;
      {pirq, irq} = 2'b11;
      cyc(4);
      check_state(st, PDM_SLEEP);
      {pirq, irq} = 2'b00;
      n0 = exc_n;
      cyc(1);
      case (s)
        0: nmi = 1;
        1: ub = 1;
        2: dbi = 1;
        3: begin iprio = mask + 4'h1; irq = 1; end
        4: begin pprio = mask + 4'h1; pirq = 1; end
        default: dbr = 1;
      endcase
      cyc(1);
      {nmi, ub, dbi, irq, pirq, dbr} = 6'h00;
      cyc(3);
      check_state(st, PDM_RUN);
      if (s < 5) check_byte(8'(exc_n - n0), 8'h01);
    end
    $display("test sleep done");
    n0 = clr_n;
    halt_to(1'b1);
    check_state(st, PDM_STANDBY);
    check_byte({5'h00, pin_en, per_en, cpu_en}, 8'h00);
    // redundancy bit is clear here, so only standby can stop this clock
    check_byte({7'h00, rclk}, 8'h00);
    check_byte(8'(clr_n - n0), 8'h01);
    sense = SENSE_LOW_LEVEL;
    irq = 1;
    cyc(20);
    check_state(st, PDM_STANDBY);
    irq = 0;
    sense = 2'h1;
    iprio = mask - 4'h1;
    n0 = res_n;
    cyc(2);
    irq = 1;
    cyc(2);
    irq = 0;
    wait_state(PDM_RUN, 1000);
    cyc(2);
    check_byte(8'(res_n - n0), 8'h01);
    wait_state(PDM_STANDBY, 1000);
    n0 = exc_n;
    nmi = 1;
    cyc(1);
    nmi = 0;
    wait_state(PDM_RUN, 1000);
    sel = 0;
    cyc(3);
    check_byte(8'(exc_n - n0), 8'h01);
    cyc(400);
    check_state(st, PDM_RUN);
    // unmasked irq wake on a two-cycle tick: settle is twice as long
    cks = 3'h1;
    halt_to(1'b1);
    iprio = mask + 4'h1;
    n0 = exc_n;
    irq = 1;
    cyc(2);
    irq = 0;
    cyc(200);
    check_state(st, PDM_SETTLE);
    wait_state(PDM_RUN, 1000);
    sel = 0;
    cyc(3);
    check_byte(8'(exc_n - n0), 8'h01);
    $display("test standby done");
    halt_to(1'b1);
    i_rst_b = 0;
    sel = 0;
    cyc(8);
    i_rst_b = 1;
    cyc(4);
    check_state(st, PDM_RUN);
    check_byte({7'h00, pin_en}, 8'h01);
    check_byte(rdata, 8'h01);
    check_byte({7'h00, hclk}, 8'h01);
    check_byte({7'h00, rclk}, 8'h00);
    $display("test reset_exit done");
    tally_and_finish();
  end
endmodule : power_down_mode_controller_tb
